// ==== inc/msq_pkg.sv ====
// Package with the register map, reset values, timing constants and types of the sequencer.
package msq_pkg;

  // ****************************************************************
  // Register byte offsets on the Wishbone bus
  // ****************************************************************
  localparam logic [7:0] ADR_CONFIG      = 8'h00;
  localparam logic [7:0] ADR_ONESHOT     = 8'h04;
  localparam logic [7:0] ADR_SAMPLE_CFG  = 8'h08;
  localparam logic [7:0] ADR_ALERT_MASK  = 8'h0C;
  localparam logic [7:0] ADR_HIGH_STATUS = 8'h10;
  localparam logic [7:0] ADR_LOW_STATUS  = 8'h14;
  localparam logic [7:0] ADR_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] ADR_IRQ_MASK    = 8'h1C;
  localparam logic [7:0] ADR_RESULT_BASE = 8'h20;
  localparam logic [7:0] ADR_POWER_BASE  = 8'h30;
  localparam logic [7:0] ADR_LIMIT_BASE  = 8'h40;
  localparam logic [7:0] ADR_STATE       = 8'h50;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFG_RATE_LSB     = 8;
  localparam int CFG_RES_LSB      = 12;
  localparam int HSTAT_CC_BIT     = 7;
  localparam int MAX_MEAS         = 4;
  localparam logic [1:0] RATE_CONTINUOUS = 2'h3;
  localparam logic [2:0] RES_FULL        = 3'h5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] CONFIG_RST     = 32'h0000_500F;
  localparam logic [31:0] SAMPLE_CFG_RST = 32'h0505_0505;
  localparam logic [31:0] LIMIT_RST      = 32'h07FF_0800;
  localparam logic [7:0]  ALERT_MASK_RST = 8'h00;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SAMPLE_BASE_NS = 2_500_000;
  localparam int RATE_SLOW_NS   = 1_000_000_000;
  localparam int SAMPLE_BASE_CYC = (SAMPLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RATE_SLOW_CYC   = RATE_SLOW_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MSQ_IDLE   = 2'b00,
    MSQ_CONV   = 2'b01,
    MSQ_UPDATE = 2'b10
  } msq_state_t;

  typedef enum logic [1:0] {
    MSQ_PH_IDLE   = 2'b00,
    MSQ_PH_SENSE  = 2'b01,
    MSQ_PH_SOURCE = 2'b10,
    MSQ_PH_DONE   = 2'b11
  } msq_phase_t;

  typedef struct packed {
    logic [2:0] unused;
    logic [1:0] avg_code;
    logic [2:0] time_code;
  } msq_meas_cfg_t;

  typedef struct packed {
    logic [3:0]  unused_hi;
    logic [11:0] upper;
    logic [3:0]  unused_lo;
    logic [11:0] lower;
  } msq_limit_t;

endpackage

// ==== logic/msq_sequencer.sv ====
// Measurement cycle sequencer with Wishbone register slave, alert and interrupt logic.
//
// Operation
// - Active: start conversion cycles repeatedly at the programmed rate interval.
// - Standby: only a one-shot request starts a cycle, and registers stay readable with stored data.
// - All measurement enables cleared means the block is in Standby.
// - One-shot request in Standby runs exactly one cycle, then returns to Standby.
// - In Active a disabled measurement is skipped and its result kept.
// - A one-shot cycle updates every measurement regardless of enables.
// - Both channels begin their measurements together at cycle start.
// - Each channel samples sense voltage first, then source voltage, each for its time.
// - Results may average the last two to eight samples.
// - Sample time and averaging are set separately per measurement and channel.
// - Result registers change only at cycle end, never during sampling.
// - Cycle end always refreshes power, high status with complete flag, low status.
// - After a cycle the alert output is active while any limit is exceeded.
// - Upper and lower limits per measurement raise alert unless masked.
// - Slowest rate is one cycle per second, faster choices above it.
// - If sampling time exceeds the rate period, convert continuously instead.
// - Resolution is selectable from six to eleven magnitude bits plus sign.
// - Sense result is signed two's complement, eleven bits plus sign by default.
`timescale 1ns/1ps
module msq_sequencer #(
  parameter int NUM_CH          = 2,
  parameter int SAMPLE_BASE_CYC = msq_pkg::SAMPLE_BASE_CYC,
  parameter int RATE_SLOW_CYC   = msq_pkg::RATE_SLOW_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic [NUM_CH*12-1:0]   adc_sense_i,
  input  wire logic [NUM_CH*11-1:0]   adc_source_i,
  input  wire logic                   mgmt_bus_clock_pin_i,
  output logic                        alert_o,
  output logic                        irq_o
);

  localparam int NUM_MEAS = 2 * NUM_CH;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0]                 cfg_reg;
  logic [31:0]                 samp_reg;
  logic [7:0]                  alert_mask;
  logic [2:0]                  irq_mask;
  logic [2:0]                  irq_stat;
  msq_pkg::msq_limit_t         lim       [msq_pkg::MAX_MEAS];
  msq_pkg::msq_meas_cfg_t      meas_cfg  [msq_pkg::MAX_MEAS];
  logic [31:0]                 samp_cyc  [msq_pkg::MAX_MEAS];
  logic signed [11:0]          hist      [msq_pkg::MAX_MEAS][8];
  logic signed [11:0]          avg_val   [msq_pkg::MAX_MEAS];
  logic [11:0]                 upd_val   [msq_pkg::MAX_MEAS];
  logic [11:0]                 result    [msq_pkg::MAX_MEAS];
  logic [15:0]                 power     [2];
  logic [msq_pkg::MAX_MEAS-1:0] take;
  logic [msq_pkg::MAX_MEAS-1:0] fresh;
  logic [msq_pkg::MAX_MEAS-1:0] cyc_en;
  logic [msq_pkg::MAX_MEAS-1:0] hi_cmp;
  logic [msq_pkg::MAX_MEAS-1:0] lo_cmp;
  logic [msq_pkg::MAX_MEAS-1:0] hi_stat;
  logic [msq_pkg::MAX_MEAS-1:0] lo_stat;
  logic [1:0]                  ch_done;
  logic [1:0]                  over;
  msq_pkg::msq_state_t         state;
  logic                        go;
  logic                        oneshot_run;
  logic                        os_pend;
  logic                        cc_flag;
  logic [31:0]                 rate_cnt;
  logic [31:0]                 period_cyc;
  logic [1:0]                  rate_code;
  logic [2:0]                  res_code;
  logic [11:0]                 res_mask;
  logic                        active;
  logic                        cont_mode;
  logic                        start_cycle;
  logic                        bus_req;
  logic                        wr_hit;
  logic                        rd_hit;
  logic [1:0]                  idx;
  logic                        idx_ok;
  logic [31:0]                 rd_mux;
  logic                        mbc_s1;
  logic                        mbc_s2;
  logic                        mbc_s3;
  logic [2:0]                  irq_evt;

  // Byte-lane merge for Wishbone writes.
  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wdat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************

  // A request is taken once; the ack that follows closes it.
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_hit  = bus_req & wb_we_i;
  assign rd_hit  = bus_req & ~wb_we_i;
  assign idx     = wb_adr_i[3:2];
  assign idx_ok  = 32'(idx) < NUM_MEAS;

  // Every access, mapped or not, is acked one cycle after it is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data is latched with the ack so it stands while ack is high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_hit) begin
      wb_dat_o <= rd_mux;
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      msq_pkg::ADR_CONFIG:      rd_mux = cfg_reg;
      msq_pkg::ADR_SAMPLE_CFG:  rd_mux = samp_reg;
      msq_pkg::ADR_ALERT_MASK:  rd_mux = {24'h000000, alert_mask};
      msq_pkg::ADR_HIGH_STATUS: rd_mux = {24'h000000, cc_flag, 3'h0, hi_stat};
      msq_pkg::ADR_LOW_STATUS:  rd_mux = {28'h0000000, lo_stat};
      msq_pkg::ADR_IRQ_STATUS:  rd_mux = {29'h00000000, irq_stat};
      msq_pkg::ADR_IRQ_MASK:    rd_mux = {29'h00000000, irq_mask};
      msq_pkg::ADR_STATE:       rd_mux = {28'h0000000, os_pend, cont_mode, state};
      default: begin
        if (idx_ok && wb_adr_i[7:4] == msq_pkg::ADR_RESULT_BASE[7:4]) begin
          rd_mux = {20'h00000, result[idx]};
        end else if (idx_ok && wb_adr_i[7:4] == msq_pkg::ADR_LIMIT_BASE[7:4]) begin
          rd_mux = lim[idx];
        end else if (32'(idx) < NUM_CH && wb_adr_i[7:4] == msq_pkg::ADR_POWER_BASE[7:4]) begin
          rd_mux = {16'h0000, power[idx[0]]};
        end
      end
    endcase
  end

  // Configuration registers written by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg    <= msq_pkg::CONFIG_RST;
      samp_reg   <= msq_pkg::SAMPLE_CFG_RST;
      alert_mask <= msq_pkg::ALERT_MASK_RST;
      irq_mask   <= msq_pkg::IRQ_MASK_RST;
    end else if (wr_hit) begin
      case (wb_adr_i)
        msq_pkg::ADR_CONFIG:     cfg_reg    <= merge_sel(cfg_reg, wb_dat_i, wb_sel_i);
        msq_pkg::ADR_SAMPLE_CFG: samp_reg   <= merge_sel(samp_reg, wb_dat_i, wb_sel_i);
        msq_pkg::ADR_ALERT_MASK: begin
          if (wb_sel_i[0]) begin
            alert_mask <= wb_dat_i[7:0];
          end
        end
        msq_pkg::ADR_IRQ_MASK: begin
          if (wb_sel_i[0]) begin
            irq_mask <= wb_dat_i[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Limit registers, one word per measurement.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < msq_pkg::MAX_MEAS; m++) begin
        lim[m] <= msq_pkg::LIMIT_RST;
      end
    end else if (wr_hit && idx_ok && wb_adr_i[7:4] == msq_pkg::ADR_LIMIT_BASE[7:4]) begin
      lim[idx] <= merge_sel(lim[idx], wb_dat_i, wb_sel_i);
    end
  end

  // ****************************************************************
  // Rate and mode decisions
  // ****************************************************************

  // Enables beyond the fitted channels are ignored.
  assign active    = |cfg_reg[NUM_MEAS-1:0];
  assign rate_code = cfg_reg[msq_pkg::CFG_RATE_LSB +: 2];
  assign res_code  = cfg_reg[msq_pkg::CFG_RES_LSB +: 3];

  // Code 0 is one cycle per second; codes 1 and 2 each double the rate, code 3 is continuous.
  assign period_cyc = 32'(RATE_SLOW_CYC) >> rate_code;
  assign cont_mode  = (rate_code == msq_pkg::RATE_CONTINUOUS) | (|over);

  // Cycles may start only from idle, so a slow rate never truncates a cycle.
  assign start_cycle = (state == msq_pkg::MSQ_IDLE) &
                       ((active & (cont_mode | (rate_cnt >= period_cyc - 32'h1))) |
                        (~active & os_pend));

  // Interval counter runs start to start; it saturates so a fresh Active start is immediate.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_cnt <= 32'hFFFF_FFFF;
    end else if (!active) begin
      rate_cnt <= 32'hFFFF_FFFF;
    end else if (start_cycle) begin
      rate_cnt <= 32'h0000_0000;
    end else if (rate_cnt != 32'hFFFF_FFFF) begin
      rate_cnt <= rate_cnt + 32'h1;
    end
  end

  // One-shot request is only accepted in Standby; a new request wins over its consumption.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      os_pend <= 1'b0;
    end else begin
      os_pend <= (wr_hit & (wb_adr_i == msq_pkg::ADR_ONESHOT) & wb_sel_i[0] & wb_dat_i[0] &
                  ~active) | (os_pend & ~start_cycle & ~active);
    end
  end

  // ****************************************************************
  // Cycle state machine
  // ****************************************************************

  // Enables are frozen at start so software changes mid-cycle do not tear a cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= msq_pkg::MSQ_IDLE;
      go          <= 1'b0;
      oneshot_run <= 1'b0;
      cyc_en      <= '0;
    end else begin
      go <= start_cycle;
      unique case (state)
        msq_pkg::MSQ_IDLE: begin
          if (start_cycle) begin
            state       <= msq_pkg::MSQ_CONV;
            oneshot_run <= ~active;
            cyc_en      <= active ? cfg_reg[msq_pkg::MAX_MEAS-1:0] : '1;
          end
        end
        msq_pkg::MSQ_CONV: begin
          if (!go && (&ch_done)) begin
            state <= msq_pkg::MSQ_UPDATE;
          end
        end
        msq_pkg::MSQ_UPDATE: begin
          state <= msq_pkg::MSQ_IDLE;
        end
        default: begin
          state <= msq_pkg::MSQ_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Per-channel sampling sequence
  // ****************************************************************
  genvar gc;
  genvar gm;
  for (gc = 0; gc < 2; gc++) begin : g_ch
    if (gc < NUM_CH) begin : g_on
      msq_pkg::msq_phase_t ph;
      logic [31:0]         cnt;

      // Sense first, then source; a disabled measurement is skipped entirely.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ph  <= msq_pkg::MSQ_PH_IDLE;
          cnt <= 32'h0000_0000;
        end else begin
          unique case (ph)
            msq_pkg::MSQ_PH_IDLE: begin
              if (go) begin
                if (cyc_en[2*gc]) begin
                  ph  <= msq_pkg::MSQ_PH_SENSE;
                  cnt <= samp_cyc[2*gc] - 32'h1;
                end else if (cyc_en[2*gc+1]) begin
                  ph  <= msq_pkg::MSQ_PH_SOURCE;
                  cnt <= samp_cyc[2*gc+1] - 32'h1;
                end else begin
                  ph <= msq_pkg::MSQ_PH_DONE;
                end
              end
            end
            msq_pkg::MSQ_PH_SENSE: begin
              if (cnt == 32'h0000_0000) begin
                if (cyc_en[2*gc+1]) begin
                  ph  <= msq_pkg::MSQ_PH_SOURCE;
                  cnt <= samp_cyc[2*gc+1] - 32'h1;
                end else begin
                  ph <= msq_pkg::MSQ_PH_DONE;
                end
              end else begin
                cnt <= cnt - 32'h1;
              end
            end
            msq_pkg::MSQ_PH_SOURCE: begin
              if (cnt == 32'h0000_0000) begin
                ph <= msq_pkg::MSQ_PH_DONE;
              end else begin
                cnt <= cnt - 32'h1;
              end
            end
            msq_pkg::MSQ_PH_DONE: begin
              if (state == msq_pkg::MSQ_UPDATE) begin
                ph <= msq_pkg::MSQ_PH_IDLE;
              end
            end
          endcase
        end
      end

      assign take[2*gc]   = (ph == msq_pkg::MSQ_PH_SENSE) & (cnt == 32'h0000_0000);
      assign take[2*gc+1] = (ph == msq_pkg::MSQ_PH_SOURCE) & (cnt == 32'h0000_0000);
      assign ch_done[gc]  = (ph == msq_pkg::MSQ_PH_DONE);
      // Summed sampling time longer than the rate period forces back-to-back cycles.
      assign over[gc] = ({1'b0, samp_cyc[2*gc]} + {1'b0, samp_cyc[2*gc+1]}) >
                        {1'b0, period_cyc};
    end else begin : g_off
      assign take[2*gc]   = 1'b0;
      assign take[2*gc+1] = 1'b0;
      assign ch_done[gc]  = 1'b1;
      assign over[gc]     = 1'b0;
    end
  end

  // ****************************************************************
  // Sample history, averaging and results
  // ****************************************************************

  // Resolution code 0..5 keeps 6..11 magnitude bits; lower bits are cleared.
  assign res_mask = (res_code >= msq_pkg::RES_FULL) ? 12'hFFF :
                    12'hFFF << (msq_pkg::RES_FULL - res_code);

  for (gm = 0; gm < msq_pkg::MAX_MEAS; gm++) begin : g_meas
    assign meas_cfg[gm] = samp_reg[8*gm +: 8];
    assign samp_cyc[gm] = 32'(SAMPLE_BASE_CYC) << meas_cfg[gm].time_code;
    if (gm < NUM_MEAS) begin : g_on
      logic signed [11:0] sample;
      logic signed [14:0] sum;

      // Sense is signed two's complement; source is unsigned and zero-extended.
      if (gm % 2 == 0) begin : g_sense
        assign sample = adc_sense_i[(gm/2)*12 +: 12];
      end else begin : g_source
        assign sample = {1'b0, adc_source_i[(gm/2)*11 +: 11]};
      end

      // History starts at zero, so early averages are diluted until it fills.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          for (int i = 0; i < 8; i++) begin
            hist[gm][i] <= 12'h000;
          end
        end else if (take[gm]) begin
          hist[gm][0] <= sample;
          for (int i = 1; i < 8; i++) begin
            hist[gm][i] <= hist[gm][i-1];
          end
        end
      end

      // Average of the newest 1, 2, 4 or 8 samples.
      always_comb begin
        sum = 15'h0000;
        for (int i = 0; i < 8; i++) begin
          if (i < (1 << meas_cfg[gm].avg_code)) begin
            sum = sum + 15'(hist[gm][i]);
          end
        end
        avg_val[gm] = 12'(sum >>> meas_cfg[gm].avg_code);
      end

      // A fresh sample waits here until the cycle ends.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          fresh[gm]  <= 1'b0;
          result[gm] <= 12'h000;
        end else if (take[gm]) begin
          fresh[gm] <= 1'b1;
        end else if (state == msq_pkg::MSQ_UPDATE) begin
          fresh[gm]  <= 1'b0;
          result[gm] <= upd_val[gm];
        end
      end

      assign upd_val[gm] = fresh[gm] ? (avg_val[gm] & res_mask) : result[gm];
      assign hi_cmp[gm]  = $signed(upd_val[gm]) > $signed(lim[gm].upper);
      assign lo_cmp[gm]  = $signed(upd_val[gm]) < $signed(lim[gm].lower);
    end else begin : g_off
      assign fresh[gm]   = 1'b0;
      assign result[gm]  = 12'h000;
      assign avg_val[gm] = 12'h000;
      assign upd_val[gm] = 12'h000;
      assign hi_cmp[gm]  = 1'b0;
      assign lo_cmp[gm]  = 1'b0;
      for (gc = 0; gc < 8; gc++) begin : g_hz
        assign hist[gm][gc] = 12'h000;
      end
    end
  end

  // ****************************************************************
  // End-of-cycle status, power, alert and interrupt
  // ****************************************************************

  // Power ratio is magnitude of sense times source, top sixteen bits kept.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power[0] <= 16'h0000;
      power[1] <= 16'h0000;
      hi_stat  <= '0;
      lo_stat  <= '0;
    end else if (state == msq_pkg::MSQ_UPDATE) begin
      for (int c = 0; c < 2; c++) begin
        power[c] <= 16'((23'(upd_val[2*c][11] ? 12'(-upd_val[2*c]) : upd_val[2*c]) *
                         23'(upd_val[2*c+1][10:0])) >> 7);
      end
      hi_stat <= hi_cmp;
      lo_stat <= lo_cmp;
    end
  end

  // Complete flag: set on each update, cleared by reading high status; set wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_flag <= 1'b0;
    end else begin
      cc_flag <= (state == msq_pkg::MSQ_UPDATE) |
                 (cc_flag & ~(rd_hit & (wb_adr_i == msq_pkg::ADR_HIGH_STATUS)));
    end
  end

  // Management clock pin is synchronised before its rising edges are counted as bus activity.
  // The stages reset to the pulled-up idle level, so release of reset shows no false edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mbc_s1 <= 1'b1;
      mbc_s2 <= 1'b1;
      mbc_s3 <= 1'b1;
    end else begin
      mbc_s1 <= mgmt_bus_clock_pin_i;
      mbc_s2 <= mbc_s1;
      mbc_s3 <= mbc_s2;
    end
  end

  assign irq_evt[0] = (state == msq_pkg::MSQ_UPDATE);
  assign irq_evt[1] = (state == msq_pkg::MSQ_UPDATE) & (|({lo_cmp, hi_cmp} & ~alert_mask));
  assign irq_evt[2] = mbc_s2 & ~mbc_s3;

  // Sticky interrupt status; a read clears it, but an event in that cycle survives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= irq_evt |
                  (irq_stat & ~{3{rd_hit & (wb_adr_i == msq_pkg::ADR_IRQ_STATUS)}});
    end
  end

  // Alert follows the limit status latched at cycle end, gated by its mask.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_o <= 1'b0;
      irq_o   <= 1'b0;
    end else begin
      alert_o <= |({lo_stat, hi_stat} & ~alert_mask);
      irq_o   <= |(irq_stat & irq_mask);
    end
  end

endmodule

// ==== tb/msq_sequencer_properties.sv ====
// Port checker for the measurement cycle sequencer, bound to its top module.
`timescale 1ns/1ps
module msq_sequencer_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        alert_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic rd;
  // A request counts only while no answer stands, so a held strobe is not taken twice.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd  = req && !wb_we_i;
  AST_ACK_NEXT: assert property (req |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_NO_SPUR: assert property (!req |=> !wb_ack_o) else $error("ack without request");
  AST_RST_QUIET: assert property (disable iff (1'b0) rst_i |=> !alert_o && !irq_o && !wb_ack_o)
    else $error("outputs active after reset");
  AST_UNMAP: assert property (rd && wb_adr_i == 8'hFC |=> wb_dat_o == 32'h0) else $error("unmapped data");
  AST_WR_HOLD: assert property (req && wb_we_i |=> $stable(wb_dat_o)) else $error("write moved data");
  AST_DAT_ACK: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("data moved without ack");
  AST_STATE_RSV: assert property (rd && wb_adr_i == msq_pkg::ADR_STATE |=> wb_dat_o[31:4] == 28'h0)
    else $error("state spare bits set");
  AST_IRQ_RSV: assert property (rd && wb_adr_i == msq_pkg::ADR_IRQ_STATUS |=> wb_dat_o[31:3] == 29'h0)
    else $error("irq spare bits set");
endmodule
bind msq_sequencer msq_sequencer_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .alert_o, .irq_o);

// ==== tb/msq_host_model.sv ====
// Host side of the management bus: makes the bus clock only inside frames.
`timescale 1ns/1ps
module msq_host_model (
  input  wire logic run_i,
  output logic      bus_clk_o
);
  // The line has a pull-up, so outside a frame it rests high instead of holding a stale level.
  initial begin
    bus_clk_o = 1'b1;
    forever begin
      #400;
      bus_clk_o = run_i ? ~bus_clk_o : 1'b1;
    end
  end
endmodule

// ==== tb/tb_msq_sequencer.sv ====
// Self-checking bench for the measurement cycle sequencer.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_msq_sequencer;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, run = 0, ack, alert_o, irq_o, bclk;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [23:0] sense = {12'h0F0, 12'h111};
  logic [21:0] source = {11'h055, 11'h200};
  int          err_total = 0, n_compared = 0;
  // Short sample and rate counts keep the run brief; expectations follow from them.
  msq_sequencer #(.SAMPLE_BASE_CYC(4), .RATE_SLOW_CYC(200)) dut (.clk_i, .rst_i,
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .adc_sense_i(sense),
    .adc_source_i(source), .mgmt_bus_clock_pin_i(bclk), .alert_o, .irq_o);
  msq_host_model host (.run_i(run), .bus_clk_o(bclk));
  initial forever #50 clk_i = ~clk_i;
  // One classic Wishbone cycle; ack is sampled as it stood before each edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin err_total++; $display("ERROR ack exp 1 got 0"); end
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, rdat & m)
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog sized well above the roughly 1,600 cycles the sequence needs.
  initial begin #1_000_000; err_total++; print_verdict(); end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(msq_pkg::ADR_CONFIG, '1, msq_pkg::CONFIG_RST);
    rd(msq_pkg::ADR_SAMPLE_CFG, '1, msq_pkg::SAMPLE_CFG_RST);
    rd(msq_pkg::ADR_LIMIT_BASE, '1, msq_pkg::LIMIT_RST);
    rd(8'hFC, '1, 32'h0);
    rd(msq_pkg::ADR_STATE, '1, 32'h5);
    $display("test reset values done");
    xfer(1'b1, msq_pkg::ADR_SAMPLE_CFG, 32'h0);
    xfer(1'b1, msq_pkg::ADR_CONFIG, 32'h0000_5000);
    repeat (600) @(posedge clk_i);
    xfer(1'b0, msq_pkg::ADR_HIGH_STATUS, 32'h0);
    repeat (300) @(posedge clk_i);
    rd(msq_pkg::ADR_HIGH_STATUS, 32'h80, 32'h0);
    // New sense 0 and source 1 inputs make those one-shot results differ from those of the first cycle.
    sense <= {12'h0F0, 12'h123};
    source <= {11'h0AA, 11'h200};
    xfer(1'b1, msq_pkg::ADR_ONESHOT, 32'h1);
    repeat (40) @(posedge clk_i);
    rd(msq_pkg::ADR_HIGH_STATUS, 32'h80, 32'h80);
    rd(msq_pkg::ADR_RESULT_BASE, 32'hFFF, 32'h123);
    rd(msq_pkg::ADR_RESULT_BASE + 8'h0C, 32'hFFF, 32'h0AA);
    rd(msq_pkg::ADR_POWER_BASE, 32'hFFFF, 32'h048C);
    repeat (300) @(posedge clk_i);
    rd(msq_pkg::ADR_HIGH_STATUS, 32'h80, 32'h0);
    rd(msq_pkg::ADR_STATE, '1, 32'h0);
    $display("test standby and one-shot done");
    sense <= {12'h0F0, 12'h456};
    source <= {11'h0AA, 11'h300};
    xfer(1'b1, msq_pkg::ADR_LIMIT_BASE + 8'h04, 32'h0010_0800);
    xfer(1'b1, msq_pkg::ADR_CONFIG, 32'h0000_5002);
    repeat (250) @(posedge clk_i);
    rd(msq_pkg::ADR_RESULT_BASE, 32'hFFF, 32'h123);
    rd(msq_pkg::ADR_RESULT_BASE + 8'h04, 32'hFFF, 32'h300);
    `CHK("alert_o", 1'b1, alert_o)
    xfer(1'b1, msq_pkg::ADR_ALERT_MASK, 32'h2);
    repeat (3) @(posedge clk_i);
    `CHK("alert_o", 1'b0, alert_o)
    $display("test active and alert done");
    xfer(1'b1, msq_pkg::ADR_IRQ_MASK, 32'h4);
    xfer(1'b0, msq_pkg::ADR_IRQ_STATUS, 32'h0);
    repeat (3) @(posedge clk_i);
    `CHK("irq_o", 1'b0, irq_o)
    // Six line toggles leave the clock at its idle high level, so no edge follows the clear.
    run <= 1'b1;
    repeat (24) @(posedge clk_i);
    run <= 1'b0;
    `CHK("irq_o", 1'b1, irq_o)
    repeat (8) @(posedge clk_i);
    rd(msq_pkg::ADR_IRQ_STATUS, 32'h4, 32'h4);
    repeat (3) @(posedge clk_i);
    `CHK("irq_o", 1'b0, irq_o)
    $display("test interrupt done");
    print_verdict();
  end
endmodule
